/* common/oks_pkg.sv */
// Purpose: Constants and types for the on-off-keying threshold slicer.
// Assumes: Strength and threshold are 8-bit codes of 0.5 dB per step.
// Notes: Byte offsets are word aligned on APB.
package oks_pkg;
  localparam logic [7:0] OFS_MAIN_MODE = 8'h00;
  localparam logic [7:0] OFS_SLICER_CFG = 8'h04;
  localparam logic [7:0] OFS_FIXED_THR = 8'h08;
  localparam logic [7:0] OFS_BIT_CYCLES = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] MAIN_MODE_RST = 8'h00;
  localparam logic [7:0] SLICER_CFG_RST = 8'h00;
  localparam logic [7:0] FIXED_THR_RST = 8'h00;
  localparam logic [15:0] BIT_CYCLES_RST = 16'h2000;
  localparam int THR_SRC_LSB = 2;
  localparam int CTRL_MANCH_BIT = 0;
  // 6 dB at 0.5 dB per code
  localparam logic [8:0] PEAK_MARGIN = 9'h00c;
  localparam int SUB_PER_CHIP_LOG2 = 4;
  localparam int AVG_FRAC = 9;

  typedef enum logic [1:0] {
    OKS_THR_FIXED = 2'b00,
    OKS_THR_PEAK = 2'b01,
    OKS_THR_AVG = 2'b10,
    OKS_THR_UNUSED = 2'b11
  } oks_thr_src_t;

  typedef struct packed {
    logic [2:0] step;
    logic [2:0] interval;
    logic [1:0] cutoff;
  } oks_slcfg_t;
endpackage : oks_pkg

/* verilog/oks_chip_timer.sv */
// Purpose: Chip timing: sixteen sub-chip ticks and one chip tick per chip.
// Assumes: bit_cycles is clock cycles per bit, at least 32.
// Notes: Chip period is truncated to a multiple of 16 clocks; sub-chip period is one sixteenth of it.
`timescale 1ns/100ps
module oks_chip_timer
  import oks_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Rate setup
  input wire logic [15:0] bit_cycles,
  input wire logic manchester,
  // Ticks
  output logic sub_tick,
  output logic chip_tick
);
  logic [15:0] chip_cycles;
  logic [11:0] sub_len;
  logic [11:0] div_cnt;
  logic [3:0] sub_cnt;
  logic [15:0] gap;
  logic [15:0] prev_cycles;
  logic rate_fresh;
  wire div_wrap = (div_cnt >= sub_len - 12'h001);
  wire sub_wrap = div_wrap && (sub_cnt == 4'hf);
  wire rate_changed = (chip_cycles != prev_cycles);

  assign chip_cycles = manchester ? {1'b0, bit_cycles[15:1]}
                       : bit_cycles;
  assign sub_len = (chip_cycles[15:4] == 12'h000) ? 12'h001
                   : chip_cycles[15:4];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 12'h000;
      sub_cnt <= 4'h0;
      sub_tick <= 1'b0;
      chip_tick <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 12'h000 : div_cnt + 12'h001;
      if (div_wrap) begin
        sub_cnt <= sub_cnt + 4'h1;
      end
      sub_tick <= div_wrap;
      chip_tick <= sub_wrap;
    end
  end

  // Cycles since the last chip tick; a rate change spoils one period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 16'h0000;
      prev_cycles <= 16'h0000;
      rate_fresh <= 1'b1;
    end else begin
      gap <= chip_tick ? 16'h0001 : gap + 16'h0001;
      prev_cycles <= chip_cycles;
      // A change in the same cycle as a tick wins over the clear
      rate_fresh <= rate_changed || (rate_fresh && !chip_tick);
    end
  end

  chip_period_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    chip_tick && !rate_fresh && !rate_changed
    |-> gap == {sub_len, 4'h0})
    else $error("chip period does not match the selected chip rate");
endmodule : oks_chip_timer

/* verilog/oks_slicer.sv */
// Purpose: OOK data slicer with fixed, peak and average thresholds.
// Assumes: signal_strength is synchronous to clock, 0.5 dB per code.
// Notes: APB slave answers in the second access cycle.
`timescale 1ns/100ps
module oks_slicer
  import oks_pkg::*;
#(
  parameter logic [15:0] BIT_CYCLES_DEF = BIT_CYCLES_RST
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Receive path
  input wire logic [7:0] signal_strength,
  output logic slice_data,
  output logic [7:0] threshold
);
  logic [7:0] main_mode_config;
  oks_slcfg_t ook_slicer_config;
  logic [7:0] fixed_thr;
  logic [15:0] bit_cycles;
  logic manchester;
  logic [7:0] peak_thr;
  logic [16:0] avg_acc;
  logic [7:0] decay_cnt;
  logic sub_tick;

  // APB decode
  wire acc = psel && penable;
  wire done = acc && pready;
  wire wr = done && pwrite;
  wire hit_main = (paddr == OFS_MAIN_MODE);
  wire hit_cfg = (paddr == OFS_SLICER_CFG);
  wire hit_fix = (paddr == OFS_FIXED_THR);
  wire hit_bit = (paddr == OFS_BIT_CYCLES);
  wire hit_ctl = (paddr == OFS_CONTROL);
  wire hit_sts = (paddr == OFS_STATUS);
  wire mapped = hit_main | hit_cfg | hit_fix | hit_bit | hit_ctl | hit_sts;
  wire [7:0] avg_thr = avg_acc[16:AVG_FRAC];
  wire [31:0] rd_mux =
    hit_main ? {24'h000000, main_mode_config} :
    hit_cfg ? {24'h000000, ook_slicer_config} :
    hit_fix ? {24'h000000, fixed_thr} :
    hit_bit ? {16'h0000, bit_cycles} :
    hit_ctl ? {31'h0, manchester} :
    hit_sts ? {8'h00, avg_thr, 7'h00, slice_data, threshold} :
    32'h00000000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !pwrite) ? rd_mux : 32'h00000000;
      pslverr <= acc && !pready && !mapped;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_mode_config <= MAIN_MODE_RST;
      ook_slicer_config <= SLICER_CFG_RST;
      fixed_thr <= FIXED_THR_RST;
      bit_cycles <= BIT_CYCLES_DEF;
      manchester <= 1'b0;
    end else if (wr) begin
      if (hit_main) main_mode_config <= pwdata[7:0];
      if (hit_cfg) ook_slicer_config <= pwdata[7:0];
      if (hit_fix) fixed_thr <= pwdata[7:0];
      if (hit_bit) bit_cycles <= pwdata[15:0];
      if (hit_ctl) manchester <= pwdata[CTRL_MANCH_BIT];
    end
  end

  oks_chip_timer oks_chip_timer_inst (
    .clock(clock),
    .rst_n(rst_n),
    .bit_cycles(bit_cycles),
    .manchester(manchester),
    .sub_tick(sub_tick),
    .chip_tick()
  );

  // Threshold source
  wire [1:0] src = main_mode_config[THR_SRC_LSB +: 2];
  wire peak_mode = (src == OKS_THR_PEAK);
  // Unused code falls back to fixed so the slicer never floats
  wire [7:0] active_thr = (src == OKS_THR_PEAK) ? peak_thr :
                          (src == OKS_THR_AVG) ? avg_thr : fixed_thr;

  // Decay step in 0.5 dB codes
  wire [7:0] step_codes =
    (ook_slicer_config.step == 3'h0) ? 8'h01 :
    (ook_slicer_config.step == 3'h1) ? 8'h02 :
    (ook_slicer_config.step == 3'h2) ? 8'h03 :
    (ook_slicer_config.step == 3'h3) ? 8'h04 :
    (ook_slicer_config.step == 3'h4) ? 8'h06 :
    (ook_slicer_config.step == 3'h5) ? 8'h08 :
    (ook_slicer_config.step == 3'h6) ? 8'h0a : 8'h0c;

  // Decay interval in sub-chip ticks (16 per chip)
  wire [2:0] ivl = ook_slicer_config.interval;
  wire [7:0] ivl_len = ivl[2] ? (8'h10 >> ivl[1:0]) >> 1
                              : 8'h10 << ivl[1:0];

  wire peak_hit = peak_mode &&
    ({1'b0, signal_strength} >= {1'b0, peak_thr} + PEAK_MARGIN);
  wire decay_fire = sub_tick && (decay_cnt >= ivl_len - 8'h01);
  wire [7:0] decayed = (peak_thr > step_codes) ?
                       peak_thr - step_codes : 8'h00;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peak_thr <= 8'h00;
      decay_cnt <= 8'h00;
    end else if (peak_hit) begin
      peak_thr <= signal_strength - PEAK_MARGIN[7:0];
      decay_cnt <= 8'h00;
    end else if (decay_fire) begin
      peak_thr <= decayed;
      decay_cnt <= 8'h00;
    end else if (sub_tick) begin
      decay_cnt <= decay_cnt + 8'h01;
    end
  end

  // Average filter: one-pole low-pass, time constant in chips
  wire [3:0] avg_shift = (ook_slicer_config.cutoff == 2'h0) ? 4'h8 :
                         (ook_slicer_config.cutoff == 2'h1) ? 4'h6 :
                         (ook_slicer_config.cutoff == 2'h2) ? 4'h5 : 4'h4;
  wire signed [17:0] avg_err = $signed({1'b0, signal_strength, 9'h000})
                               - $signed({1'b0, avg_acc});
  wire signed [17:0] avg_adj = avg_err >>> avg_shift;
  wire [17:0] avg_sum = {1'b0, avg_acc} + avg_adj;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avg_acc <= 17'h00000;
    end else if (sub_tick) begin
      avg_acc <= avg_sum[16:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slice_data <= 1'b0;
      threshold <= 8'h00;
    end else begin
      slice_data <= signal_strength > active_thr;
      threshold <= active_thr;
    end
  end

  peak_load_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    peak_hit |=> peak_thr == $past(signal_strength) - PEAK_MARGIN[7:0])
    else $error("peak capture loaded a wrong threshold");
  decay_step_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    decay_fire && !peak_hit && peak_thr > step_codes
    |=> peak_thr == $past(peak_thr) - $past(step_codes))
    else $error("decay did not lower threshold by the step");
  step_code_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    ook_slicer_config.step == 3'h7 |-> step_codes == 8'h0c)
    else $error("largest decay step is not 6 dB");
  interval_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    ivl == 3'h3 && sub_tick && !peak_hit && decay_cnt < 8'h7f
    |=> peak_thr == $past(peak_thr))
    else $error("decay fired before eight chips elapsed");
  fast_decay_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    ivl == 3'h7 && sub_tick && !peak_hit && peak_thr != 8'h00
    |=> peak_thr < $past(peak_thr))
    else $error("decay missed a sub-chip tick at sixteen per chip");
  reset_cfg_a: assert property (
    @(posedge clock)
    $rose(rst_n) |-> ook_slicer_config == 8'h00)
    else $error("slicer config not at reset value");
  slice_cmp_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    ##1 slice_data == ($past(signal_strength) > $past(active_thr)))
    else $error("slice output disagrees with threshold compare");
  mode_sel_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    src == 2'b10 |=> threshold == $past(avg_thr))
    else $error("average threshold not selected");
  unused_sel_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    src == 2'b11 |=> threshold == $past(fixed_thr))
    else $error("unused source code did not fall back to fixed");
  restart_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    peak_hit |=> decay_cnt == 8'h00)
    else $error("peak capture did not restart decay timer");
  floor_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    decay_fire && !peak_hit && peak_thr <= step_codes
    |=> peak_thr == 8'h00)
    else $error("decay went below zero");
  // Bus answers after exactly one wait cycle
  apb_wait_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    psel && penable && !pready |=> pready)
    else $error("bus access got no answer after one wait");
  unmapped_err_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    psel && penable && !pready && !mapped |=> pslverr)
    else $error("unmapped access did not raise the error flag");
endmodule : oks_slicer

/* dv/oks_strength_model.sv */
// Purpose: Strength source standing in for the receiver measurement path.
// Assumes: The bench sets the levels and the bit length in clocks.
// Notes: Alternation gives a one-zero pattern with no long runs.
`timescale 1ns/100ps
module oks_strength_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pattern setup
  input wire logic [7:0] level_hi,
  input wire logic [7:0] level_lo,
  input wire logic alternate,
  input wire logic [15:0] bit_len,
  // Strength out
  output logic [7:0] signal_strength
);
  logic [15:0] cnt;
  logic low_half;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      low_half <= 1'b0;
    end else if (cnt >= bit_len - 16'h0001) begin
      cnt <= 16'h0000;
      low_half <= ~low_half;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  assign signal_strength = (alternate && low_half) ? level_lo : level_hi;
endmodule : oks_strength_model

/* dv/ook_peak_threshold_slicer_tb.sv */
// Purpose: Self-checking bench for the OOK threshold slicer.
// Assumes: APB slave answers with pready; bit period is 64 clocks.
// Notes: A short bit period keeps decay gaps to a few hundred clocks.
`timescale 1ns/100ps
module ook_peak_threshold_slicer_tb import oks_pkg::*;;
  localparam logic [15:0] BITC = 16'h0040;
  localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                       8'h06, 8'h08, 8'h0a, 8'h0c};
  localparam logic [7:0] OFS [5] = '{OFS_MAIN_MODE, OFS_SLICER_CFG,
                                     OFS_FIXED_THR, OFS_BIT_CYCLES,
                                     OFS_CONTROL};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, slice_data, last_err;
  logic [31:0] prdata, rd;
  logic [7:0] threshold, signal_strength, v1;
  logic [7:0] lvl_hi = 8'h00;
  logic [7:0] lvl_lo = 8'h00;
  logic alternate = 1'b0;
  int checks = 0;
  int n_fail = 0;
  int gap, t0;

  always #2.5 clock = ~clock;

  oks_slicer #(.BIT_CYCLES_DEF(BITC)) oks_slicer_inst (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .signal_strength(signal_strength),
    .slice_data(slice_data), .threshold(threshold));

  oks_strength_model oks_strength_model_inst (
    .clock(clock), .rst_n(rst_n), .level_hi(lvl_hi), .level_lo(lvl_lo),
    .alternate(alternate), .bit_len(BITC),
    .signal_strength(signal_strength));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_chg(output int t);
    logic [7:0] old;
    old = threshold;
    t = 0;
    while (threshold === old && t < 2000) begin
      @(posedge clock);
      t++;
    end
  endtask : wait_chg

  // Full strength pins the threshold at 0xf3 until released
  task automatic decay(input logic [7:0] cfg, input int eg,
                       input logic [7:0] es);
    apb(1'b1, OFS_SLICER_CFG, {24'h0, cfg}, rd);
    lvl_hi <= 8'hff;
    repeat (4) @(posedge clock);
    chk(threshold, 8'hf3);
    lvl_hi <= 8'h00;
    wait_chg(t0);
    v1 = threshold;
    wait_chg(gap);
    chk(32'(gap), 32'(eg));
    chk(32'(v1 - threshold), 32'(es));
  endtask : decay

  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, OFS[i], 32'h0, rd);
      chk(rd, (i == 3) ? 32'(BITC) : 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0, rd);
    chk({rd[30:0], last_err}, 32'h1);
    apb(1'b1, OFS_FIXED_THR, 32'h40, rd);
    for (int i = 0; i < 3; i++) begin
      lvl_hi <= 8'h3f + 8'(i);
      repeat (3) @(posedge clock);
      chk(slice_data, 32'(i == 2));
    end
    apb(1'b1, OFS_MAIN_MODE, 32'hc, rd);
    repeat (2) @(posedge clock);
    chk({24'h0, threshold}, 32'h40);
    apb(1'b0, OFS_STATUS, 32'h0, rd);
    chk({23'h0, rd[8:0]}, 32'h140);
    apb(1'b1, OFS_MAIN_MODE, 32'h4, rd);
    for (int i = 0; i < 8; i++) begin
      decay({i[2:0], i[2:0], 2'b00}, (i < 4) ? (64 << i) : (64 >> (i - 3)),
            STEPS[i]);
    end
    decay(8'hfc, 4, 8'h0c);
    apb(1'b0, OFS_SLICER_CFG, 32'h0, rd);
    chk(rd, 32'hfc);
    repeat (300) @(posedge clock);
    chk({slice_data, threshold}, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'h1, rd);
    decay({3'b001, 3'b100, 2'b00}, 16, 8'h02);
    apb(1'b1, OFS_CONTROL, 32'h0, rd);
    apb(1'b1, OFS_SLICER_CFG, 32'h3, rd);
    apb(1'b1, OFS_MAIN_MODE, 32'h8, rd);
    lvl_hi <= 8'h60;
    lvl_lo <= 8'h20;
    alternate <= 1'b1;
    repeat (1600) @(posedge clock);
    chk(32'(threshold > 8'h20 && threshold < 8'h60), 32'h1);
    final_report();
  end

  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    final_report();
  end
endmodule : ook_peak_threshold_slicer_tb
